// ---- src/jpsp_regs.vh ----
`ifndef JPSP_REGS_VH
`define JPSP_REGS_VH
// Register byte offsets.
`define JPSP_CTRL_OFF      4'h0
`define JPSP_PROBE_SEL_OFF 4'h4
`define JPSP_STATUS_OFF    4'h8
`define JPSP_FUSE_OFF      4'hc
// Control fields.
`define JPSP_CTRL_FLEX_BIT   0
`define JPSP_CTRL_TRSTEN_BIT 1
`define JPSP_CTRL_PRA_EN_BIT 2
`define JPSP_CTRL_PRB_EN_BIT 3
`define JPSP_CTRL_CKSUM_BIT  4
`define JPSP_CTRL_RESET      5'h01
// Probe select fields.
`define JPSP_SEL_A_LSB 0
`define JPSP_SEL_B_LSB 8
// Fuse key written to blow the probe disable or the security fuse.
`define JPSP_FUSE_PROBE_KEY 32'h0000_00a5
`define JPSP_FUSE_SEC_KEY   32'h0000_005a
// Test state machine codes (four-bit standard encoding).
`define JPSP_TLR     4'hf
`define JPSP_RTI     4'hc
`define JPSP_SEL_DR  4'h7
`define JPSP_SEL_IR  4'h4
`define JPSP_TLR_TMS_HIGH_CYCLES 3'd5
// AXI responses.
`define JPSP_RESP_OKAY   2'b00
`define JPSP_RESP_SLVERR 2'b10
`endif

// ---- src/jpsp_top.v ----
// Contract
// - Flexible mode: TMS low hands TCK, TDI, TDO pins to boundary scan.
// - Pins stay in test use until the test state machine reaches logic reset.
// - Five TCK cycles with TMS high reach logic reset; tester supplies them.
// - Dedicated mode: TMS drives the standard test state machine, no pin sharing.
// - Enabled test reset pin is active-low async reset; here it is synchronised and acts on clk_i; else it is user I/O.
// - TDO drives as output during a checksum, then returns to user I/O.
// - Two probe pins each output any selected internal node in real time.
// - Probe output can be permanently disabled; here rst_i clears probe_dis_reg.
// - Each probe pin can act as ordinary user I/O instead.
// - Test reset held low keeps controller in logic reset; no probing.
// - Programmed security fuse disables test access and probe circuitry.
`timescale 1ns/1ps
`default_nettype none
`include "jpsp_regs.vh"
module jpsp_top #(
  parameter NODE_W = 256
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              awvalid,
  output wire              awready,
  input  wire [31:0]       awaddr,
  input  wire              wvalid,
  output wire              wready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  output reg               bvalid,
  input  wire              bready,
  output reg  [1:0]        bresp,
  input  wire              arvalid,
  output wire              arready,
  input  wire [31:0]       araddr,
  output reg               rvalid,
  input  wire              rready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  input  wire              tck_pin_i,
  input  wire              tms_pin_i,
  input  wire              tdi_pin_i,
  input  wire              trst_pin_i,
  input  wire              tdo_user_i,
  input  wire              tdo_user_oe_i,
  input  wire              tdo_scan_i,
  input  wire              pra_user_i,
  input  wire              pra_user_oe_i,
  input  wire              prb_user_i,
  input  wire              prb_user_oe_i,
  input  wire [NODE_W-1:0] node_i,
  output reg               tdo_o,
  output reg               tdo_oe_o,
  output reg               probe_out_a_o,
  output reg               probe_out_a_oe_o,
  output reg               probe_out_b_o,
  output reg               probe_out_b_oe_o,
  output wire              scan_owns_pins_o,
  output wire              scan_reset_n_o,
  output wire [3:0]        tap_state_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, a change counts when 2 and 3 agree.
  // ----------------------------------------------------------------
  reg [2:0] tck_s_reg;
  reg [2:0] tms_s_reg;
  reg [2:0] trst_s_reg;
  reg [2:0] tdi_s_reg;
  reg       tck_q_reg;
  reg       tms_q_reg;
  reg       trst_q_reg;
  reg       tdi_q_reg;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tck_s_reg  <= 3'b000;
      tms_s_reg  <= 3'b111;
      trst_s_reg <= 3'b111;
      tdi_s_reg  <= 3'b000;
      tck_q_reg  <= 1'b0;
      tms_q_reg  <= 1'b1;
      trst_q_reg <= 1'b1;
      tdi_q_reg  <= 1'b0;
    end else begin
      tck_s_reg  <= {tck_s_reg[1:0], tck_pin_i};
      tms_s_reg  <= {tms_s_reg[1:0], tms_pin_i};
      trst_s_reg <= {trst_s_reg[1:0], trst_pin_i};
      tdi_s_reg  <= {tdi_s_reg[1:0], tdi_pin_i};
      if (tck_s_reg[1] == tck_s_reg[2])
        tck_q_reg <= tck_s_reg[2];
      if (tms_s_reg[1] == tms_s_reg[2])
        tms_q_reg <= tms_s_reg[2];
      if (trst_s_reg[1] == trst_s_reg[2])
        trst_q_reg <= trst_s_reg[2];
      if (tdi_s_reg[1] == tdi_s_reg[2])
        tdi_q_reg <= tdi_s_reg[2];
    end
  end
  wire tck_rise = tck_s_reg[1] & tck_s_reg[2] & ~tck_q_reg;

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  reg  [4:0]  ctrl_reg;
  reg  [15:0] sel_reg;
  reg         probe_dis_reg;
  reg         secure_reg;
  wire        flex_mode  = ctrl_reg[`JPSP_CTRL_FLEX_BIT];
  wire        trst_en    = ctrl_reg[`JPSP_CTRL_TRSTEN_BIT];
  wire        cksum_busy = ctrl_reg[`JPSP_CTRL_CKSUM_BIT];
  // The pin reset is only honoured when that pin is given to the test logic.
  wire        trst_low   = trst_en & ~trst_q_reg;
  wire        scan_rst   = trst_low | secure_reg;
  assign scan_reset_n_o = ~scan_rst;

  // ----------------------------------------------------------------
  // Test state machine, stepped on sampled TCK rising edges.
  // ----------------------------------------------------------------
  reg [3:0] tap_reg;
  reg [3:0] tap_next;
  always @* begin
    case (tap_reg)
      4'hf: tap_next = tms_q_reg ? 4'hf : 4'hc;
      4'hc: tap_next = tms_q_reg ? 4'h7 : 4'hc;
      4'h7: tap_next = tms_q_reg ? 4'h4 : 4'h6;
      4'h4: tap_next = tms_q_reg ? 4'hf : 4'he;
      4'h6: tap_next = tms_q_reg ? 4'h1 : 4'h2;
      4'h2: tap_next = tms_q_reg ? 4'h1 : 4'h2;
      4'h1: tap_next = tms_q_reg ? 4'h5 : 4'h3;
      4'h3: tap_next = tms_q_reg ? 4'h0 : 4'h3;
      4'h0: tap_next = tms_q_reg ? 4'h5 : 4'h2;
      4'h5: tap_next = tms_q_reg ? 4'h7 : 4'hc;
      4'he: tap_next = tms_q_reg ? 4'h9 : 4'ha;
      4'ha: tap_next = tms_q_reg ? 4'h9 : 4'ha;
      4'h9: tap_next = tms_q_reg ? 4'hd : 4'hb;
      4'hb: tap_next = tms_q_reg ? 4'h8 : 4'hb;
      4'h8: tap_next = tms_q_reg ? 4'hd : 4'ha;
      4'hd: tap_next = tms_q_reg ? 4'h7 : 4'hc;
      default: tap_next = `JPSP_TLR;
    endcase
  end
  reg scan_own_reg;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tap_reg      <= `JPSP_TLR;
      scan_own_reg <= 1'b0;
    end else if (scan_rst) begin
      tap_reg      <= `JPSP_TLR;
      scan_own_reg <= 1'b0;
    end else if (tck_rise) begin
      tap_reg <= tap_next;
      // Takeover is decided only on a test clock edge, never mid-cycle.
      if (!tms_q_reg)
        scan_own_reg <= 1'b1;
      else if (tap_next == `JPSP_TLR)
        scan_own_reg <= 1'b0;
    end
  end
  assign tap_state_o = tap_reg;
  // Dedicated mode: pins belong to scan whenever the fuse allows it.
  assign scan_owns_pins_o = ~secure_reg & (flex_mode ? scan_own_reg : 1'b1);
  wire tap_active = (tap_reg != `JPSP_TLR) & ~scan_rst;

  // ----------------------------------------------------------------
  // Pin muxing.
  // ----------------------------------------------------------------
  wire probe_ok = ~probe_dis_reg & ~secure_reg & tap_active;
  wire pa_on    = probe_ok & ctrl_reg[`JPSP_CTRL_PRA_EN_BIT];
  wire pb_on    = probe_ok & ctrl_reg[`JPSP_CTRL_PRB_EN_BIT];
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tdo_o            <= 1'b0;
      tdo_oe_o         <= 1'b0;
      probe_out_a_o    <= 1'b0;
      probe_out_a_oe_o <= 1'b0;
      probe_out_b_o    <= 1'b0;
      probe_out_b_oe_o <= 1'b0;
    end else begin
      if (cksum_busy & ~secure_reg) begin
        tdo_o    <= tdo_scan_i;
        tdo_oe_o <= 1'b1;
      end else if (scan_owns_pins_o) begin
        tdo_o    <= tdo_scan_i;
        tdo_oe_o <= tap_active;
      end else begin
        tdo_o    <= tdo_user_i;
        tdo_oe_o <= tdo_user_oe_i;
      end
      // Both probes run at once from separate selects.
      probe_out_a_o    <= pa_on ? node_i[sel_reg[7:0]] : pra_user_i;
      probe_out_a_oe_o <= pa_on | pra_user_oe_i & ~pa_on;
      probe_out_b_o    <= pb_on ? node_i[sel_reg[15:8]] : prb_user_i;
      probe_out_b_oe_o <= pb_on | prb_user_oe_i & ~pb_on;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave: one write and one read at a time.
  // ----------------------------------------------------------------
  reg        aw_got_reg;
  reg        w_got_reg;
  reg [3:0]  aw_addr_reg;
  reg        aw_hi_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  assign awready = ~aw_got_reg & ~bvalid;
  assign wready  = ~w_got_reg & ~bvalid;
  assign arready = ~rvalid;
  wire do_wr = aw_got_reg & w_got_reg & ~bvalid;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 4'h0;
      aw_hi_reg     <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      bvalid        <= 1'b0;
      bresp         <= `JPSP_RESP_OKAY;
      ctrl_reg      <= `JPSP_CTRL_RESET;
      sel_reg       <= 16'h0000;
      probe_dis_reg <= 1'b0;
      secure_reg    <= 1'b0;
      rvalid        <= 1'b0;
      rdata         <= 32'h0000_0000;
      rresp         <= `JPSP_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= awaddr[3:0];
        // Upper address bits must be zero, or the offset would alias a register.
        aw_hi_reg   <= |awaddr[31:4];
      end
      if (wvalid && wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (do_wr) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= `JPSP_RESP_OKAY;
        if (aw_hi_reg)
          bresp <= `JPSP_RESP_SLVERR;
        else case (aw_addr_reg)
          `JPSP_CTRL_OFF: begin
            if (w_strb_reg[0])
              ctrl_reg <= w_data_reg[4:0];
          end
          `JPSP_PROBE_SEL_OFF: begin
            if (w_strb_reg[0])
              sel_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1])
              sel_reg[15:8] <= w_data_reg[15:8];
          end
          `JPSP_FUSE_OFF: begin
            // One-way bits: nothing but reset clears them.
            if (w_strb_reg == 4'hf && w_data_reg == `JPSP_FUSE_PROBE_KEY)
              probe_dis_reg <= 1'b1;
            if (w_strb_reg == 4'hf && w_data_reg == `JPSP_FUSE_SEC_KEY)
              secure_reg <= 1'b1;
          end
          `JPSP_STATUS_OFF: bresp <= `JPSP_RESP_OKAY;
          default: bresp <= `JPSP_RESP_SLVERR;
        endcase
      end
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `JPSP_RESP_OKAY;
        if (|araddr[31:4]) begin
          rdata <= 32'h0000_0000;
          rresp <= `JPSP_RESP_SLVERR;
        end else case (araddr[3:0])
          `JPSP_CTRL_OFF:      rdata <= {27'h0, ctrl_reg};
          `JPSP_PROBE_SEL_OFF: rdata <= {16'h0, sel_reg};
          `JPSP_STATUS_OFF:    rdata <= {20'h0, tap_reg, tdi_q_reg, trst_q_reg, tms_q_reg,
                                         scan_own_reg, pb_on, pa_on, probe_dis_reg, secure_reg};
          `JPSP_FUSE_OFF:      rdata <= {30'h0, probe_dis_reg, secure_reg};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `JPSP_RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule // jpsp_top
`default_nettype wire

// ---- tb/jpsp_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module jpsp_chk (
  input wire       clk_i,
  input wire       rst_i,
  input wire       awready,
  input wire       wready,
  input wire       bvalid,
  input wire       bready,
  input wire [1:0] bresp,
  input wire       arready,
  input wire       rvalid,
  input wire       tck_pin_i,
  input wire       scan_owns_pins_o,
  input wire       scan_reset_n_o,
  input wire [3:0] tap_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [2:0] tck_age;
  reg       tck_q;
  // The pin synchroniser lets the state move only a few clocks after a pin edge.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tck_age <= 3'h0;
      tck_q   <= 1'h0;
    end else begin
      tck_q   <= tck_pin_i;
      tck_age <= (tck_q != tck_pin_i) ? 3'h0 : tck_age + {2'h0, tck_age != 3'h7};
    end
  end
  chk_tap_on_clock:
  assert property ($changed(tap_state_o) && scan_reset_n_o && $past(scan_reset_n_o)
    |-> tck_age != 3'h7) else $error("tap moved without a test clock edge");
  chk_release_tlr:
  assert property ($fell(scan_owns_pins_o) |-> tap_state_o == 4'hf || !scan_reset_n_o)
    else $error("pins released outside logic reset");
  chk_hold_test:
  assert property (scan_reset_n_o && tap_state_o != 4'hf |-> scan_owns_pins_o)
    else $error("pins left test use early");
  chk_trst_tlr:
  assert property (!scan_reset_n_o [*2] |-> tap_state_o == 4'hf)
    else $error("test reset did not hold logic reset");
  chk_trst_pins:
  assert property (!scan_reset_n_o [*2] |-> !scan_owns_pins_o)
    else $error("pins kept in test use under reset");
  chk_bresp_hold:
  assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_aw_refuse:
  assert property (bvalid |-> !awready && !wready) else $error("write taken too soon");
  chk_ar_refuse:
  assert property (rvalid |-> !arready) else $error("read taken too soon");
  cover property ($rose(scan_owns_pins_o));
  cover property (tap_state_o == 4'h2);
  cover property (bvalid && bready && bresp == 2'h2);
endmodule // jpsp_chk
bind jpsp_top jpsp_chk u_jpsp_chk (.*);
`default_nettype wire

// ---- tb/jpsp_tester.sv ----
`timescale 1ns/1ps
`default_nettype none
module jpsp_tester (
  input  wire  clk_i,
  output logic tck_o,
  output logic tms_o,
  output logic trst_n_o
);
  initial {tck_o, tms_o, trst_n_o} = 3'h3;
  // The test clock stands low between frames; 4 clocks low, 4 high is 320 ns.
  task automatic pulse(input logic tms);
    @(posedge clk_i);
    tms_o <= tms;
    repeat (3) @(posedge clk_i);
    tck_o <= 1'h1;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'h0;
  endtask
  task automatic set_trst(input logic lvl);
    @(posedge clk_i);
    trst_n_o <= lvl;
  endtask
endmodule // jpsp_tester
`default_nettype wire

// ---- tb/tb_jpsp_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "jpsp_regs.vh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
module tb_jpsp_top;
  logic         clk_i = 1'h0, rst_i = 1'h1, awvalid = 1'h0, wvalid = 1'h0;
  logic         bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0]   wstrb = 4'hf;
  logic [31:0]  awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, x;
  logic [255:0] node_i = 256'h0;
  logic [7:0]   usr = 8'h0, sa, tms_walk = 8'hf2;
  logic [3:0]   tap;
  logic [1:0]   bresp, rresp, r;
  logic         awready, wready, bvalid, arready, rvalid, tdo, tdo_oe, pa, pa_oe;
  logic         pb, pb_oe, own, srst_n, tck, tms, trst_n;
  int           mismatches = 0, n_checks = 0, cyc = 0, seed = 90, i;
  jpsp_top u_jpsp_top (.clk_i(clk_i), .rst_i(rst_i), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .tck_pin_i(tck), .tms_pin_i(tms), .tdi_pin_i(usr[7]), .trst_pin_i(trst_n),
    .tdo_user_i(usr[0]), .tdo_user_oe_i(usr[1]), .tdo_scan_i(usr[6]), .pra_user_i(usr[2]),
    .pra_user_oe_i(usr[3]), .prb_user_i(usr[4]), .prb_user_oe_i(usr[5]), .node_i(node_i),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .probe_out_a_o(pa), .probe_out_a_oe_o(pa_oe),
    .probe_out_b_o(pb), .probe_out_b_oe_o(pb_oe), .scan_owns_pins_o(own),
    .scan_reset_n_o(srst_n), .tap_state_o(tap));
  jpsp_tester u_jpsp_tester (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .trst_n_o(trst_n));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Every channel is released, and the answer taken, at the edge of its handshake.
  task automatic axi(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    logic done;
    @(posedge clk_i);
    {awaddr, wdata, araddr, wstrb} <= {a, d, a, s};
    {awvalid, wvalid, arvalid} <= {w, w, !w};
    {bready, rready} <= {w, !w};
    done = 1'h0;
    while (!done) begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (arvalid && arready) arvalid <= 1'h0;
      if (w ? bvalid && bready : rvalid && rready) begin
        done = 1'h1;
        {x, r} = w ? {32'h0, bresp} : {rdata, rresp};
        {bready, rready} <= 2'h0;
      end
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    axi(1'h1, a, d, 4'hf);
    `CHK("bresp", `JPSP_RESP_OKAY, r)
  endtask
  task automatic stir;
    @(posedge clk_i);
    node_i <= {8{$random(seed)}};
    usr <= 8'($random(seed));
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    axi(1'h0, `JPSP_CTRL_OFF, 32'h0, 4'hf);
    `CHK("ctrl reset", {32'h1, `JPSP_RESP_OKAY}, {x, r})
    axi(1'h1, `JPSP_PROBE_SEL_OFF, 32'h0000_3c5a, 4'h1);
    axi(1'h0, `JPSP_PROBE_SEL_OFF, 32'h0, 4'hf);
    `CHK("sel strobe", 32'h5a, x)
    axi(1'h1, `JPSP_FUSE_OFF, `JPSP_FUSE_PROBE_KEY, 4'h7);
    axi(1'h0, `JPSP_FUSE_OFF, 32'h0, 4'hf);
    `CHK("fuse strobe", 32'h0, x)
    stir;
    `CHK("own idle", 1'h0, own)
    u_jpsp_tester.pulse(1'h0);
    stir;
    `CHK("own taken", {1'h1, `JPSP_RTI}, {own, tap})
    for (i = 1; i < 8; i++) u_jpsp_tester.pulse(tms_walk[i]);
    stir;
    `CHK("own held", 1'h1, own)
    u_jpsp_tester.pulse(1'h1);
    stir;
    `CHK("own freed", {1'h0, `JPSP_TLR}, {own, tap})
    wr(`JPSP_CTRL_OFF, 32'h0);
    stir;
    `CHK("own fixed", 1'h1, own)
    sa = 8'($random(seed));
    wr(`JPSP_PROBE_SEL_OFF, {16'h0, 8'hff, sa});
    wr(`JPSP_CTRL_OFF, 32'hd);
    u_jpsp_tester.pulse(1'h0);
    repeat (3) begin
      stir;
      `CHK("probes", {2'h3, node_i[sa], node_i[255]}, {pa_oe, pb_oe, pa, pb})
    end
    wr(`JPSP_CTRL_OFF, 32'h9);
    stir;
    `CHK("probe a user", usr[3:2], {pa_oe, pa})
    u_jpsp_tester.set_trst(1'h0);
    repeat (2) stir;
    `CHK("trst ignored", {1'h1, `JPSP_RTI}, {srst_n, tap})
    wr(`JPSP_CTRL_OFF, 32'hf);
    stir;
    `CHK("trst", {1'h0, `JPSP_TLR, usr[5:4]}, {srst_n, tap, pb_oe, pb})
    u_jpsp_tester.set_trst(1'h1);
    wr(`JPSP_CTRL_OFF, 32'h11);
    stir;
    `CHK("checksum", {2'h1, usr[6]}, {own, tdo_oe, tdo})
    wr(`JPSP_CTRL_OFF, 32'h1);
    stir;
    `CHK("tdo user", usr[1:0], {tdo_oe, tdo})
    wr(`JPSP_FUSE_OFF, `JPSP_FUSE_PROBE_KEY);
    wr(`JPSP_CTRL_OFF, 32'hd);
    u_jpsp_tester.pulse(1'h0);
    stir;
    `CHK("probe fused", {1'h1, usr[3:2]}, {own, pa_oe, pa})
    axi(1'h0, `JPSP_FUSE_OFF, 32'h0, 4'hf);
    `CHK("fuse", 32'h2, x)
    wr(`JPSP_FUSE_OFF, `JPSP_FUSE_SEC_KEY);
    wr(`JPSP_CTRL_OFF, 32'h0);
    stir;
    `CHK("secured", 2'h0, {srst_n, own})
    axi(1'h0, `JPSP_STATUS_OFF, 32'h0, 4'hf);
    `CHK("status", {4'hf, 7'h43}, {x[11:8], x[6:0]})
    axi(1'h1, 32'h10, 32'h0, 4'hf);
    `CHK("unmapped", `JPSP_RESP_SLVERR, r)
    axi(1'h0, 32'h10, 32'h0, 4'hf);
    `CHK("rd unmapped", {32'h0, `JPSP_RESP_SLVERR}, {x, r})
    // A second reset must clear the one-way bits and hand the pins back.
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    axi(1'h0, `JPSP_FUSE_OFF, 32'h0, 4'hf);
    `CHK("fuse cleared", {32'h0, `JPSP_RESP_OKAY}, {x, r})
    `CHK("own after reset", 2'h2, {srst_n, own})
    test_done;
  end
endmodule // tb_jpsp_top
`default_nettype wire
